// ### ctl_lines_cfg.svh
// constants for the peripheral control line logic: control bit positions,
// write mask and reset values; included by bare name, definitions only.
// Function
// - A-side strobe active edge sets flag bit 7
// - bit 1 picks edge: 0 falling, 1 rising
// - request low when bit 7 and bit 0
// - flag sets regardless of enable bit 0
// - bit 5 zero: dual line input, sets bit 6
// - bit 3 enables bit 6 onto request
// - A handshake: strobe sets high, read sets low
// - A pulse: low one cycle after read
// - manual output follows bit 3
// - B-side strobe line mirrors the A side
// - B-side dual input modes mirror A side
// - B handshake: write sets low, strobe high
// - B pulse: low one cycle after write
// - B output modes triggered by writes
// - port data read clears both flags
`ifndef CTL_LINES_CFG_SVH
`define CTL_LINES_CFG_SVH
`define CTL_EN1_BIT 0
`define CTL_EDGE1_BIT 1
`define CTL_EN2_BIT 3
`define CTL_EDGE2_BIT 4
`define CTL_DIR2_BIT 5
`define CTL_FLAG2_BIT 6
`define CTL_FLAG1_BIT 7
`define CTL_WMASK 8'h3f
`define CTL_RESET 8'h00
`define DUAL_OUT_RESET 1'b1
// edges after reset during which the detector only tracks the pin
`define SYNC_PRIME_CNT 2'h3
`endif

// ### ctl_lines_pkg.sv
// types shared by the control line logic.
// assumes the constants come from ctl_lines_cfg.svh.
package ctl_lines_pkg;
   // what the dual-purpose line is doing
   typedef enum logic [1:0] {
      mode_input,
      mode_handshake,
      mode_pulse,
      mode_manual
   } dual_mode_type;
endpackage

// ### edge_if.sv
// carrier between the main block and one edge detector.
// assumes both ends share mclk.
`timescale 1ns/100ps
interface edge_if;
   logic rising_sel; // 1 selects low-to-high as the active edge
   logic hit;        // one-cycle pulse per qualifying edge
   modport detector (input rising_sel, output hit);
   modport user (output rising_sel, input hit);
endinterface

// ### line_edge_sync.sv
// synchroniser and active-edge detector for one control line pin.
// assumes the pin is asynchronous to mclk; rst is synchronous high.
`timescale 1ns/100ps
`include "ctl_lines_cfg.svh"
module line_edge_sync (
   input wire logic mclk,
   input wire logic rst,
   input wire logic pin,
   edge_if.detector port
);
   logic s1_reg; // first stage, read only by s2_reg
   logic s2_reg;
   logic s3_reg;
   logic lvl_reg; // last accepted level
   logic [1:0] prime_cnt_reg; // edges spent filling the stages after reset
   logic primed; // stages hold the pin; edges may count from now
   logic agree_new; // stages agree on a changed level

   // three-stage synchroniser
   always_ff @(posedge mclk) begin
      if (rst) begin
         s1_reg <= 1'b0;
         s2_reg <= 1'b0;
         s3_reg <= 1'b0;
      end else begin
         s1_reg <= pin;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end

   // a change counts once stages two and three agree
   assign agree_new = (s2_reg == s3_reg) && (s3_reg != lvl_reg);
   assign primed = (prime_cnt_reg == `SYNC_PRIME_CNT);

   // accepted level; while the stages still hold reset zeros the level
   // tracks stage two, so an idle-high pin claims no edge after reset
   always_ff @(posedge mclk) begin
      if (rst) begin
         lvl_reg <= 1'b0;
         prime_cnt_reg <= 2'h0;
      end else if (!primed) begin
         prime_cnt_reg <= prime_cnt_reg + 2'h1;
         lvl_reg <= s2_reg;
      end else if (agree_new) begin
         lvl_reg <= s3_reg;
      end
   end

   // one pulse per qualifying edge, polarity chosen by the user
   always_ff @(posedge mclk) begin
      if (rst) begin
         port.hit <= 1'b0;
      end else begin
         port.hit <= agree_new && primed
            && (s3_reg == port.rising_sel);
      end
   end
endmodule

// ### ctl_lines.sv
// control line logic for both sides: flags, requests, dual line drive.
// assumes strobes are one-cycle pulses on mclk, decoded outside.
`timescale 1ns/100ps
`include "ctl_lines_cfg.svh"
module ctl_lines (
   input wire logic mclk,
   input wire logic rst,
   input wire logic a_strobe_in,
   input wire logic b_strobe_in,
   input wire logic a_dual_in,
   input wire logic b_dual_in,
   input wire logic a_ctl_wr,
   input wire logic b_ctl_wr,
   input wire logic [7:0] ctl_wdata,
   input wire logic a_data_rd,
   input wire logic b_data_rd,
   input wire logic b_data_wr,
   output logic [7:0] a_ctl_rdata,
   output logic [7:0] b_ctl_rdata,
   output logic a_request_n,
   output logic b_request_n,
   output logic a_dual_out,
   output logic a_dual_oe,
   output logic b_dual_out,
   output logic b_dual_oe
);
   import ctl_lines_pkg::*;

   logic [1:0] strobe_pin; // input-only lines, index 0 is side A
   logic [1:0] dual_pin; // dual-purpose lines as inputs
   logic [1:0] ctl_wr; // control register write strobes
   logic [1:0] clr_rd; // port data read, clears both flags
   logic [1:0] trig; // output-mode trigger: A read, B write
   logic [7:0] ctl_reg [2]; // control registers, flags in bits 7 and 6
   logic [7:0] ctl_next [2];
   logic [1:0] req_n_reg; // active-low requests
   logic [1:0] out_reg; // dual line output level
   logic [1:0] oe_reg; // dual line drive enable
   logic [1:0] hit1; // strobe line active edge pulses
   logic [1:0] hit2; // dual line active edge pulses

   assign strobe_pin = {b_strobe_in, a_strobe_in};
   assign dual_pin = {b_dual_in, a_dual_in};
   assign ctl_wr = {b_ctl_wr, a_ctl_wr};
   assign clr_rd = {b_data_rd, a_data_rd};
   // side B acts on data writes, side A on data reads
   assign trig = {b_data_wr, a_data_rd};

   // outputs come straight from the flops
   assign a_ctl_rdata = ctl_reg[0];
   assign b_ctl_rdata = ctl_reg[1];
   assign a_request_n = req_n_reg[0];
   assign b_request_n = req_n_reg[1];
   assign a_dual_out = out_reg[0];
   assign b_dual_out = out_reg[1];
   assign a_dual_oe = oe_reg[0];
   assign b_dual_oe = oe_reg[1];

   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);

   // both sides share one structure
   for (genvar s = 0; s < 2; s++) begin : g_side
      edge_if e1 ();
      edge_if e2 ();
      dual_mode_type mode; // mode chosen by the next control value

      line_edge_sync u_strobe (
         .mclk(mclk),
         .rst(rst),
         .pin(strobe_pin[s]),
         .port(e1.detector)
      );
      line_edge_sync u_dual (
         .mclk(mclk),
         .rst(rst),
         .pin(dual_pin[s]),
         .port(e2.detector)
      );

      // edge polarity straight from the control bits
      assign e1.rising_sel = ctl_reg[s][`CTL_EDGE1_BIT];
      assign e2.rising_sel = ctl_reg[s][`CTL_EDGE2_BIT];
      assign hit1[s] = e1.hit;
      assign hit2[s] = e2.hit;

      // next control value; a set arriving with the read clear wins
      always_comb begin
         ctl_next[s] = ctl_reg[s];
         if (ctl_wr[s]) begin
            ctl_next[s] = (ctl_reg[s] & ~`CTL_WMASK)
               | (ctl_wdata & `CTL_WMASK);
         end
         if (clr_rd[s]) begin
            ctl_next[s][`CTL_FLAG1_BIT] = 1'b0;
            ctl_next[s][`CTL_FLAG2_BIT] = 1'b0;
         end
         // set regardless of the enable
         if (hit1[s]) begin
            ctl_next[s][`CTL_FLAG1_BIT] = 1'b1;
         end
         // dual edges count only in input mode
         if (hit2[s] && !ctl_reg[s][`CTL_DIR2_BIT]) begin
            ctl_next[s][`CTL_FLAG2_BIT] = 1'b1;
         end
      end

      // mode decode for the dual line
      always_comb begin
         unique case ({ctl_next[s][`CTL_DIR2_BIT],
                       ctl_next[s][`CTL_EDGE2_BIT],
                       ctl_next[s][`CTL_EN2_BIT]})
            3'h4: mode = mode_handshake;
            3'h5: mode = mode_pulse;
            3'h6, 3'h7: mode = mode_manual;
            default: mode = mode_input; // bit 5 clear: all input codes
         endcase
      end

      // control register with its flags
      always_ff @(posedge mclk) begin
         if (rst) begin
            ctl_reg[s] <= `CTL_RESET;
         end else begin
            ctl_reg[s] <= ctl_next[s];
         end
      end

      // request follows the next flags so it moves with them
      always_ff @(posedge mclk) begin
         if (rst) begin
            req_n_reg[s] <= 1'b1;
         end else begin
            req_n_reg[s] <= ~((ctl_next[s][`CTL_FLAG1_BIT]
               & ctl_next[s][`CTL_EN1_BIT])
               | (ctl_next[s][`CTL_FLAG2_BIT]
               & ctl_next[s][`CTL_EN2_BIT]
               & ~ctl_next[s][`CTL_DIR2_BIT]));
         end
      end

      // dual line drive; in handshake the strobe edge beats the trigger
      always_ff @(posedge mclk) begin
         if (rst) begin
            out_reg[s] <= `DUAL_OUT_RESET;
            oe_reg[s] <= 1'b0;
         end else begin
            oe_reg[s] <= ctl_next[s][`CTL_DIR2_BIT];
            unique case (mode)
               mode_input: out_reg[s] <= `DUAL_OUT_RESET;
               mode_handshake: begin
                  if (hit1[s]) begin
                     out_reg[s] <= 1'b1;
                  end else if (trig[s]) begin
                     out_reg[s] <= 1'b0;
                  end
               end
               // low for exactly the cycle after the trigger
               mode_pulse: out_reg[s] <= ~trig[s];
               mode_manual: begin
                  out_reg[s] <= ctl_next[s][`CTL_EN2_BIT];
               end
            endcase
         end
      end

      // checks on this side
      a_flag1_set: assert property (hit1[s] |=> ctl_reg[s][7])
         else $error("strobe edge did not set flag 7");
      a_flag2_set: assert property (
         hit2[s] && !ctl_reg[s][5] |=> ctl_reg[s][6])
         else $error("dual edge did not set flag 6");
      a_flag_clear: assert property (
         clr_rd[s] && !hit1[s] && !hit2[s]
         |=> !ctl_reg[s][7] && !ctl_reg[s][6])
         else $error("data read did not clear flags");
      a_request_level: assert property (
         req_n_reg[s] == ~((ctl_reg[s][7] & ctl_reg[s][0])
         | (ctl_reg[s][6] & ctl_reg[s][3] & ~ctl_reg[s][5])))
         else $error("request level disagrees with flags");
      a_request_masked: assert property (
         hit1[s] && !ctl_wr[s] && !ctl_reg[s][0] && !ctl_reg[s][3]
         |=> req_n_reg[s] && ctl_reg[s][7])
         else $error("masked flag reached request");
      a_input_float: assert property (
         !ctl_reg[s][5] |-> !oe_reg[s])
         else $error("dual line driven in input mode");
      a_manual_level: assert property (
         ctl_reg[s][5:4] == 2'h3 |-> oe_reg[s] && out_reg[s] == ctl_reg[s][3])
         else $error("manual level wrong");
      a_pulse_shape: assert property (
         ctl_reg[s][5:3] == 3'h5 && $past(ctl_reg[s][5:3]) == 3'h5
         |-> out_reg[s] == !$past(trig[s]))
         else $error("pulse output wrong");
      a_hs_set: assert property (
         ctl_reg[s][5:3] == 3'h4 && hit1[s] && !ctl_wr[s] |=> out_reg[s])
         else $error("handshake not raised by strobe");
      a_hs_clear: assert property (
         ctl_reg[s][5:3] == 3'h4 && trig[s] && !hit1[s] && !ctl_wr[s]
         |=> !out_reg[s])
         else $error("handshake not lowered by trigger");
      // strobe flag 7 holds until read; output modes drive and ignore dual edges
      a_flag_hold: assert property (
         ctl_reg[s][7] && !clr_rd[s] |=> ctl_reg[s][7])
         else $error("strobe flag lost without a data read");
      a_output_drive: assert property (
         ctl_reg[s][5] |-> oe_reg[s])
         else $error("dual line not driven in output mode");
      a_dual_ignored: assert property (
         hit2[s] && ctl_reg[s][5] && !ctl_reg[s][6] |=> !ctl_reg[s][6])
         else $error("dual edge set flag 6 in output mode");

      c_flag_request: cover property (hit1[s] && ctl_reg[s][0]
         ##1 !req_n_reg[s]);
      c_pulse: cover property (ctl_reg[s][5:3] == 3'h5 && trig[s]
         ##1 !out_reg[s] ##1 out_reg[s]);
      c_handshake: cover property (ctl_reg[s][5:3] == 3'h4 && trig[s]
         ##[1:20] hit1[s]);
      c_clear: cover property (ctl_reg[s][7] && clr_rd[s]);
   end
endmodule

// ### per_dev.sv
// peripheral model: drives the strobe and dual lines, follows dual outputs.
// assumes the bench calls its tasks just after a falling edge of mclk.
`timescale 1ns/100ps
module per_dev (
   input wire logic mclk,
   input wire logic a_dual_out,
   input wire logic a_dual_oe,
   input wire logic b_dual_out,
   input wire logic b_dual_oe,
   output logic a_strobe_in,
   output logic b_strobe_in,
   output logic a_dual_in,
   output logic b_dual_in
);
   // drive levels: a strobe, b strobe, a dual, b dual
   logic [3:0] drv = 4'hf;
   assign a_strobe_in = drv[0];
   assign b_strobe_in = drv[1];
   // the adapter wins the dual pin while it drives it
   assign a_dual_in = a_dual_oe ? a_dual_out : drv[2];
   assign b_dual_in = b_dual_oe ? b_dual_out : drv[3];
   // set one line; index is line * 2 + side
   task set_pin(input int k, input logic v);
      drv[k] = v;
   endtask
   // new data only after the adapter pulled the dual line low
   task offer_a(output bit ok);
      ok = 0;
      for (int i = 0; i < 20 && !ok; i++) begin
         @(negedge mclk);
         ok = (a_dual_in === 1'b0);
      end
      if (ok) drv[0] = ~drv[0];
   endtask
endmodule

// ### tb.sv
// self-checking bench for ctl_lines with a peripheral model on its pins.
// assumes the control constants come from ctl_lines_cfg.svh.
`timescale 1ns/100ps
`include "ctl_lines_cfg.svh"
module tb;
   typedef struct {int sel; logic [7:0] exp;} note_type;
   logic mclk = 1'b0, rst = 1'b1;
   logic a_ctl_wr = 0, b_ctl_wr = 0, a_data_rd = 0, b_data_rd = 0;
   logic b_data_wr = 0;
   logic [7:0] ctl_wdata = 8'h00, a_ctl_rdata, b_ctl_rdata;
   logic a_strobe_in, b_strobe_in, a_dual_in, b_dual_in;
   logic a_request_n, b_request_n, a_dual_out, a_dual_oe;
   logic b_dual_out, b_dual_oe;
   int error_cnt = 0, comparisons = 0;
   note_type q[$]; // expected results, oldest first
   event chk;
   bit ok;
   note_type n_cur; // note being compared
   always #2.5 mclk = ~mclk;
   ctl_lines ctl_lines_inst (.mclk(mclk), .rst(rst),
      .a_strobe_in(a_strobe_in), .b_strobe_in(b_strobe_in),
      .a_dual_in(a_dual_in), .b_dual_in(b_dual_in), .a_ctl_wr(a_ctl_wr),
      .b_ctl_wr(b_ctl_wr), .ctl_wdata(ctl_wdata), .a_data_rd(a_data_rd),
      .b_data_rd(b_data_rd), .b_data_wr(b_data_wr),
      .a_ctl_rdata(a_ctl_rdata), .b_ctl_rdata(b_ctl_rdata),
      .a_request_n(a_request_n), .b_request_n(b_request_n),
      .a_dual_out(a_dual_out), .a_dual_oe(a_dual_oe),
      .b_dual_out(b_dual_out), .b_dual_oe(b_dual_oe));
   per_dev per_dev_inst (.mclk(mclk), .a_dual_out(a_dual_out),
      .a_dual_oe(a_dual_oe), .b_dual_out(b_dual_out), .b_dual_oe(b_dual_oe),
      .a_strobe_in(a_strobe_in), .b_strobe_in(b_strobe_in),
      .a_dual_in(a_dual_in), .b_dual_in(b_dual_in));
   // result picker: registers, requests, dual line out and enable
   function automatic logic [7:0] seen(int sel);
      case (sel)
         0: return a_ctl_rdata;
         1: return b_ctl_rdata;
         2: return {7'h0, a_request_n};
         3: return {7'h0, b_request_n};
         4: return {6'h0, a_dual_out, a_dual_oe};
         default: return {6'h0, b_dual_out, b_dual_oe};
      endcase
   endfunction
   task note(input int sel, input logic [7:0] exp);
      q.push_back('{sel, exp});
      ->chk;
   endtask
   // one compare task per kind of result; even selectors are side a
   task cmp_reg(input int sel, input logic [7:0] exp);
      comparisons++;
      if (seen(sel) !== exp) begin
         error_cnt++;
         $display("MISMATCH %s_ctl_rdata exp %h seen %h",
            sel[0] ? "b" : "a", exp, seen(sel));
      end
   endtask
   task cmp_req(input int sel, input logic [7:0] exp);
      comparisons++;
      if (seen(sel) !== exp) begin
         error_cnt++;
         $display("MISMATCH %s_request_n exp %h seen %h",
            sel[0] ? "b" : "a", exp, seen(sel));
      end
   endtask
   task cmp_dual(input int sel, input logic [7:0] exp);
      comparisons++;
      if (seen(sel) !== exp) begin
         error_cnt++;
         $display("MISMATCH %s_dual_out_oe exp %h seen %h",
            sel[0] ? "b" : "a", exp, seen(sel));
      end
   endtask
   // watcher: outputs are settled at the falling edge when notes arrive
   initial forever begin
      @chk;
      while (q.size() > 0) begin
         n_cur = q.pop_front();
         if (n_cur.sel < 2) cmp_reg(n_cur.sel, n_cur.exp);
         else if (n_cur.sel < 4) cmp_req(n_cur.sel, n_cur.exp);
         else cmp_dual(n_cur.sel, n_cur.exp);
      end
   end
   task wait_n(input int k);
      repeat (k) @(negedge mclk);
   endtask
   task wr_ctl(input logic side, input logic [7:0] d);
      ctl_wdata = d;
      if (side) b_ctl_wr = 1'b1;
      else a_ctl_wr = 1'b1;
      @(negedge mclk);
      a_ctl_wr = 1'b0;
      b_ctl_wr = 1'b0;
   endtask
   // one-cycle port data read on a side
   task trig_rd(input logic side);
      if (side) b_data_rd = 1'b1;
      else a_data_rd = 1'b1;
      @(negedge mclk);
      a_data_rd = 1'b0;
      b_data_rd = 1'b0;
   endtask
   // output trigger: reads on side a, writes on side b
   task set_go(input logic side, input logic v);
      if (side) b_data_wr = v;
      else a_data_rd = v;
   endtask
   task end_sim;
      // notes never compared count as misses
      error_cnt += q.size();
      $display("checks %0d errors %0d", comparisons, error_cnt);
      if (error_cnt == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // generous bound: the tests need well under 1000 cycles
   initial begin
      #20000;
      error_cnt++;
      end_sim;
   end
   initial begin
      logic [7:0] c, r, f;
      logic s, ln, e, n;
      void'($urandom(32'h1ae9));
      wait_n(4);
      rst = 1'b0;
      @(negedge mclk);
      note(0, 8'h00);
      note(2, 8'h01);
      note(5, 8'h02);
      // every side, line, edge and enable; bits 7:6 and 2 random
      for (int i = 0; i < 16; i++) begin
         {n, e, ln, s} = 4'(i);
         // park the pin at its active level so the next move is inactive
         per_dev_inst.set_pin({ln, s}, e);
         c = ln ? {3'h0, e, n, 3'h0} : {6'h0, e, n};
         f = ln ? 8'h40 : 8'h80;
         r = 8'($urandom) & 8'hc4;
         wait_n(8);
         wr_ctl(s, c | r);
         c = c | (r & `CTL_WMASK);
         trig_rd(s);
         note(s, c);
         per_dev_inst.set_pin({ln, s}, ~e);
         wait_n(8);
         note(s, c);
         per_dev_inst.set_pin({ln, s}, e);
         wait_n(8);
         note(s, c | f);
         note(2 + s, {7'h0, ~n});
         trig_rd(s);
         note(2 + s, 8'h01);
      end
      // output modes: manual, back-to-back pulses, handshake
      for (int t = 0; t < 2; t++) begin
         s = t[0];
         per_dev_inst.set_pin(t, 1'b1);
         wr_ctl(s, 8'h30);
         @(negedge mclk);
         note(4 + t, 8'h01);
         wr_ctl(s, 8'h38);
         @(negedge mclk);
         note(4 + t, 8'h03);
         wr_ctl(s, 8'h28);
         set_go(s, 1'b1);
         @(negedge mclk);
         note(4 + t, 8'h01);
         @(negedge mclk);
         note(4 + t, 8'h01);
         set_go(s, 1'b0);
         @(negedge mclk);
         note(4 + t, 8'h03);
         wr_ctl(s, 8'h20);
         @(negedge mclk);
         note(4 + t, 8'h03);
         set_go(s, 1'b1);
         @(negedge mclk);
         set_go(s, 1'b0);
         wait_n(3);
         note(4 + t, 8'h01);
         if (t == 0) per_dev_inst.offer_a(ok);
         else per_dev_inst.set_pin(1, 1'b0);
         wait_n(8);
         note(4 + t, 8'h03);
      end
      // second reset in mid-run; the idle-high dual pin must give no edge
      rst = 1'b1;
      wait_n(2);
      rst = 1'b0;
      wr_ctl(1'b0, 8'h10);
      wait_n(8);
      note(0, 8'h10);
      note(2, 8'h01);
      note(4, 8'h02);
      // let the watcher take the last notes before the verdict
      @(negedge mclk);
      end_sim;
   end
endmodule
